//--- io_space_defs.svh
`ifndef IO_SPACE_DEFS_SVH
`define IO_SPACE_DEFS_SVH

// ----------------------------------------------------------------
// Address ranges
// ----------------------------------------------------------------
`define IO_LOC_COUNT 64
`define BIT_ACCESS_LAST 6'h1f
`define DATA_ALIAS_BASE 9'h020
`define EXT_SPACE_FIRST 9'h060
`define EXT_SPACE_LAST 9'h1ff
`define RESET_BYTE 8'h00

// ----------------------------------------------------------------
// I/O locations
// ----------------------------------------------------------------
`define LOC_PORT_B_INPUT_PINS 6'h03
`define LOC_PORT_B_DIRECTION 6'h04
`define LOC_PORT_B_OUTPUT_LATCH 6'h05
`define LOC_PORT_C_INPUT_PINS 6'h06
`define LOC_PORT_C_DIRECTION 6'h07
`define LOC_PORT_C_OUTPUT_LATCH 6'h08
`define LOC_PORT_D_INPUT_PINS 6'h09
`define LOC_PORT_D_DIRECTION 6'h0a
`define LOC_PORT_D_OUTPUT_LATCH 6'h0b
`define LOC_TIMER0_EVENT_FLAGS 6'h15
`define LOC_TIMER1_EVENT_FLAGS 6'h16
`define LOC_PIN_CHANGE_FLAGS 6'h1b
`define LOC_EXTERNAL_IRQ_FLAGS 6'h1c
`define LOC_EXTERNAL_IRQ_MASK 6'h1d
`define LOC_GENERAL_SCRATCH_0 6'h1e
`define LOC_NVM_DATA_CONTROL 6'h1f
`define LOC_NVM_DATA_BYTE 6'h20
`define LOC_NVM_ADDRESS_LOW 6'h21
`define LOC_NVM_ADDRESS_HIGH 6'h22
`define LOC_TIMER_PRESCALER_SYNC 6'h23
`define LOC_TIMER0_CONTROL_A 6'h24
`define LOC_TIMER0_CONTROL_B 6'h25
`define LOC_TIMER0_COUNT 6'h26
`define LOC_TIMER0_COMPARE_A 6'h27
`define LOC_TIMER0_COMPARE_B 6'h28
`define LOC_PLL_CONTROL_STATUS 6'h29
`define LOC_GENERAL_SCRATCH_1 6'h2a
`define LOC_GENERAL_SCRATCH_2 6'h2b
`define LOC_SERIAL_PERIPH_STATUS 6'h2d
`define LOC_SERIAL_PERIPH_DATA 6'h2e
`define LOC_COMPARATOR_CTRL 6'h30
`define LOC_DEBUG_LINK_DATA 6'h31

// ----------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------
`define MASK_FULL 8'hff
`define MASK_PORT_C 8'hf7
`define MASK_TIMER0_FLAGS 8'h07
`define MASK_TIMER1_FLAGS 8'h2f
`define MASK_PIN_CHANGE 8'h03
`define MASK_NVM_CONTROL 8'h3f
`define MASK_NVM_ADDR_HIGH 8'h0f
`define MASK_PRESCALER_SYNC 8'h83
`define MASK_TIMER0_CTRL_A 8'hf3
`define MASK_TIMER0_CTRL_B 8'hcf
`define MASK_PLL 8'h1f
`define MASK_SERIAL_STATUS 8'hc1

`endif

//--- io_space_pkg.sv
package io_space_pkg;

  // Core operations presented to the register space
  typedef enum logic [2:0] {
    op_none,
    op_io_in,
    op_io_out,
    op_set_io_bit,
    op_clear_io_bit,
    op_test_io_bit,
    op_data_load,
    op_data_store
  } core_op_t;

  // One core request per cycle
  typedef struct packed {
    core_op_t op;
    logic [8:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } core_req_t;

  // Answer to the core
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic bit_val;
  } core_resp_t;

  // Access forwarded to the extended space
  typedef struct packed {
    logic sel;
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } ext_req_t;

  // Hardware flag set pulses
  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] pin_change;
    logic [7:0] external_irq;
  } flag_set_t;

  // Sampled port pin levels
  typedef struct packed {
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] port_d;
  } pin_in_t;

  // Whole state of the register space
  typedef struct packed {
    logic [63:0][7:0] mem;
    core_resp_t resp;
    ext_req_t ext;
  } io_state_t;

endpackage

//--- io_register_space.sv
`timescale 1ns/1ps
`include "io_space_defs.svh"

module io_register_space (
  input wire logic i_clk,
  input wire logic i_reset,
  input io_space_pkg::core_req_t i_req,
  output io_space_pkg::core_resp_t o_resp,
  input io_space_pkg::pin_in_t i_pins,
  input io_space_pkg::flag_set_t i_flag_set,
  output logic [63:0][7:0] o_io_regs,
  output io_space_pkg::ext_req_t o_ext,
  input wire logic [7:0] i_ext_rdata
);
  import io_space_pkg::*;

  // ----------------------------------------------------------------
  // Location decode functions
  // ----------------------------------------------------------------

  // Bits that really exist at a location, zero where unassigned
  function automatic logic [7:0] impl_mask(input logic [5:0] loc);
    case (loc)
      `LOC_PORT_B_INPUT_PINS,
      `LOC_PORT_B_DIRECTION,
      `LOC_PORT_B_OUTPUT_LATCH,
      `LOC_PORT_D_INPUT_PINS,
      `LOC_PORT_D_DIRECTION,
      `LOC_PORT_D_OUTPUT_LATCH,
      `LOC_EXTERNAL_IRQ_FLAGS,
      `LOC_EXTERNAL_IRQ_MASK,
      `LOC_GENERAL_SCRATCH_0,
      `LOC_NVM_DATA_BYTE,
      `LOC_NVM_ADDRESS_LOW,
      `LOC_TIMER0_COUNT,
      `LOC_TIMER0_COMPARE_A,
      `LOC_TIMER0_COMPARE_B,
      `LOC_GENERAL_SCRATCH_1,
      `LOC_GENERAL_SCRATCH_2,
      `LOC_SERIAL_PERIPH_DATA,
      `LOC_COMPARATOR_CTRL,
      `LOC_DEBUG_LINK_DATA: impl_mask = `MASK_FULL;
      `LOC_PORT_C_INPUT_PINS,
      `LOC_PORT_C_DIRECTION,
      `LOC_PORT_C_OUTPUT_LATCH: impl_mask = `MASK_PORT_C;
      `LOC_TIMER0_EVENT_FLAGS: impl_mask = `MASK_TIMER0_FLAGS;
      `LOC_TIMER1_EVENT_FLAGS: impl_mask = `MASK_TIMER1_FLAGS;
      `LOC_PIN_CHANGE_FLAGS: impl_mask = `MASK_PIN_CHANGE;
      `LOC_NVM_DATA_CONTROL: impl_mask = `MASK_NVM_CONTROL;
      `LOC_NVM_ADDRESS_HIGH: impl_mask = `MASK_NVM_ADDR_HIGH;
      `LOC_TIMER_PRESCALER_SYNC: impl_mask = `MASK_PRESCALER_SYNC;
      `LOC_TIMER0_CONTROL_A: impl_mask = `MASK_TIMER0_CTRL_A;
      `LOC_TIMER0_CONTROL_B: impl_mask = `MASK_TIMER0_CTRL_B;
      `LOC_PLL_CONTROL_STATUS: impl_mask = `MASK_PLL;
      `LOC_SERIAL_PERIPH_STATUS: impl_mask = `MASK_SERIAL_STATUS;
      default: impl_mask = 8'h00;
    endcase
  endfunction

  // Locations whose flags clear when a one is written
  function automatic logic is_w1c(input logic [5:0] loc);
    case (loc)
      `LOC_TIMER0_EVENT_FLAGS,
      `LOC_TIMER1_EVENT_FLAGS,
      `LOC_PIN_CHANGE_FLAGS,
      `LOC_EXTERNAL_IRQ_FLAGS: is_w1c = 1'b1;
      default: is_w1c = 1'b0;
    endcase
  endfunction

  // Locations that show the port pins and ignore writes
  function automatic logic is_pins(input logic [5:0] loc);
    case (loc)
      `LOC_PORT_B_INPUT_PINS,
      `LOC_PORT_C_INPUT_PINS,
      `LOC_PORT_D_INPUT_PINS: is_pins = 1'b1;
      default: is_pins = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  io_state_t st_q; // Registered state
  io_state_t st_d; // Next state
  logic [5:0] loc; // Decoded I/O location
  logic hit; // Request reaches the bank
  logic wr_en; // Request writes the bank
  logic [7:0] rd_val; // Current value at the location
  logic [7:0] wr_val; // Value written to the location
  logic [7:0] bit_one; // One-hot of the selected bit

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Map both access paths onto one location
  always_comb
  begin
    loc = i_req.addr[5:0];
    hit = 1'b0;
    wr_en = 1'b0;
    case (i_req.op)
      // Six address bits reach the full 64 locations
      op_io_in: hit = 1'b1;
      op_io_out:
      begin
        hit = 1'b1;
        wr_en = 1'b1;
      end
      // Bit operations stop at the low half
      op_set_io_bit,
      op_clear_io_bit:
      begin
        hit = (i_req.addr[5:0] <= `BIT_ACCESS_LAST);
        wr_en = hit;
      end
      op_test_io_bit: hit = (i_req.addr[5:0] <= `BIT_ACCESS_LAST);
      // Data alias sits 0x20 above the I/O location
      op_data_load,
      op_data_store:
      begin
        loc = 6'(i_req.addr - `DATA_ALIAS_BASE);
        hit = (i_req.addr >= `DATA_ALIAS_BASE) && (i_req.addr < `EXT_SPACE_FIRST);
        wr_en = hit && (i_req.op == op_data_store);
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Read and write values
  // ----------------------------------------------------------------

  // Current value, pins for input locations, zero on absent bits
  always_comb
  begin
    bit_one = 8'h01 << i_req.bit_sel;
    case (loc)
      `LOC_PORT_B_INPUT_PINS: rd_val = i_pins.port_b;
      `LOC_PORT_C_INPUT_PINS: rd_val = i_pins.port_c & `MASK_PORT_C;
      `LOC_PORT_D_INPUT_PINS: rd_val = i_pins.port_d;
      default: rd_val = st_q.mem[loc] & impl_mask(loc);
    endcase
    // Bit operations write back the whole register
    case (i_req.op)
      op_set_io_bit: wr_val = rd_val | bit_one;
      op_clear_io_bit: wr_val = rd_val & ~bit_one;
      default: wr_val = i_req.wdata;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Update the bank, the answer and the extended access
  always_comb
  begin
    st_d = st_q;
    st_d.resp.ack = 1'b0;
    st_d.ext.sel = 1'b0;
    st_d.ext.we = 1'b0;
    // Local access completes in one cycle
    if (i_req.op != op_none && !(i_req.op inside {op_data_load, op_data_store} && i_req.addr >= `EXT_SPACE_FIRST))
    begin
      st_d.resp.ack = 1'b1;
      st_d.resp.rdata = hit ? rd_val : 8'h00;
      st_d.resp.bit_val = hit ? rd_val[i_req.bit_sel] : 1'b0;
    end
    // Extended space is reached only from data operations
    if (i_req.op inside {op_data_load, op_data_store} && i_req.addr >= `EXT_SPACE_FIRST)
    begin
      st_d.ext.sel = 1'b1;
      st_d.ext.we = (i_req.op == op_data_store);
      st_d.ext.addr = i_req.addr;
      st_d.ext.wdata = i_req.wdata;
    end
    // Extended load returns one cycle after its strobe
    if (st_q.ext.sel && !st_q.ext.we)
    begin
      st_d.resp.ack = 1'b1;
      st_d.resp.rdata = i_ext_rdata;
      st_d.resp.bit_val = 1'b0;
    end
    // Write into the bank; absent bits and pin locations stay zero
    if (wr_en && !is_pins(loc))
    begin
      if (is_w1c(loc))
        st_d.mem[loc] = st_q.mem[loc] & ~(wr_val & impl_mask(loc));
      else
        st_d.mem[loc] = wr_val & impl_mask(loc);
    end
    // Hardware events set flags and win over a clear
    st_d.mem[`LOC_TIMER0_EVENT_FLAGS] = st_d.mem[`LOC_TIMER0_EVENT_FLAGS]
      | (i_flag_set.timer0 & `MASK_TIMER0_FLAGS);
    st_d.mem[`LOC_TIMER1_EVENT_FLAGS] = st_d.mem[`LOC_TIMER1_EVENT_FLAGS]
      | (i_flag_set.timer1 & `MASK_TIMER1_FLAGS);
    st_d.mem[`LOC_PIN_CHANGE_FLAGS] = st_d.mem[`LOC_PIN_CHANGE_FLAGS]
      | (i_flag_set.pin_change & `MASK_PIN_CHANGE);
    st_d.mem[`LOC_EXTERNAL_IRQ_FLAGS] = st_d.mem[`LOC_EXTERNAL_IRQ_FLAGS]
      | i_flag_set.external_irq;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Synchronous reset returns every bit to its reset value
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q.mem <= {`IO_LOC_COUNT{`RESET_BYTE}};
      st_q.resp <= '0;
      st_q.ext <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_resp = st_q.resp;
  assign o_ext = st_q.ext;
  assign o_io_regs = st_q.mem;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Bit operations above the low half leave the register alone
  bit_range_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op inside {op_set_io_bit, op_clear_io_bit} && i_req.addr[5:0] > `BIT_ACCESS_LAST)
    |=> st_q.mem[$past(i_req.addr[5:0])] == $past(st_q.mem[i_req.addr[5:0]]))
    else $error("bit operation changed a high location");

  // Bit test answers with the tested bit
  bit_test_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_test_io_bit && i_req.addr[5:0] == `LOC_GENERAL_SCRATCH_0)
    |=> o_resp.ack && o_resp.bit_val == $past(st_q.mem[`LOC_GENERAL_SCRATCH_0][i_req.bit_sel]))
    else $error("bit test value wrong");

  // Writing zero to a flag register with no event keeps it
  flag_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_out && i_req.addr[5:0] == `LOC_EXTERNAL_IRQ_FLAGS
      && i_req.wdata == 8'h00 && i_flag_set.external_irq == 8'h00)
    |=> $stable(st_q.mem[`LOC_EXTERNAL_IRQ_FLAGS]))
    else $error("zero write changed flags");

  // Writing ones with no event clears the flags
  flag_one_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_out && i_req.addr[5:0] == `LOC_EXTERNAL_IRQ_FLAGS
      && i_req.wdata == 8'hff && i_flag_set.external_irq == 8'h00)
    |=> st_q.mem[`LOC_EXTERNAL_IRQ_FLAGS] == 8'h00)
    else $error("one write did not clear flags");

  // Event in the clearing cycle survives
  flag_set_wins_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_flag_set.timer0[0]) |=> st_q.mem[`LOC_TIMER0_EVENT_FLAGS][0])
    else $error("flag event lost");

  // Bit set on a flag register clears every set flag
  rmw_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_set_io_bit && i_req.addr[5:0] == `LOC_TIMER1_EVENT_FLAGS
      && i_flag_set.timer1 == 8'h00)
    |=> st_q.mem[`LOC_TIMER1_EVENT_FLAGS] == 8'h00)
    else $error("read-modify-write left a flag set");

  // Store through the data alias shows at the I/O location
  alias_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_data_store && i_req.addr == 9'h04b)
    |=> o_io_regs[`LOC_GENERAL_SCRATCH_2] == $past(i_req.wdata))
    else $error("alias store not visible");

  // Load through the data alias returns the I/O register
  alias_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_data_load && i_req.addr == 9'h03e)
    |=> o_resp.ack && o_resp.rdata == $past(o_io_regs[`LOC_GENERAL_SCRATCH_0]))
    else $error("alias load differs from I/O register");

  // Data accesses below the alias base touch nothing
  data_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_data_store && i_req.addr < `DATA_ALIAS_BASE)
    |=> o_resp.ack && $stable(o_io_regs))
    else $error("low data store changed the bank");

  // Output to the top of the range lands there
  io_out_high_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_out && i_req.addr[5:0] == `LOC_DEBUG_LINK_DATA)
    |=> o_io_regs[`LOC_DEBUG_LINK_DATA] == $past(i_req.wdata))
    else $error("high location write lost");

  // Bit set in the low half raises the chosen bit
  set_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_set_io_bit && i_req.addr[5:0] == `LOC_PORT_B_OUTPUT_LATCH)
    |=> o_io_regs[`LOC_PORT_B_OUTPUT_LATCH][$past(i_req.bit_sel)])
    else $error("bit set did not take");

  // Bit clear in the low half drops the chosen bit
  clear_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_clear_io_bit && i_req.addr[5:0] == `LOC_PORT_B_OUTPUT_LATCH)
    |=> !o_io_regs[`LOC_PORT_B_OUTPUT_LATCH][$past(i_req.bit_sel)])
    else $error("bit clear did not take");

  // A one clears only its own flag
  flag_single_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_out && i_req.addr[5:0] == `LOC_TIMER0_EVENT_FLAGS
      && i_req.wdata == 8'h01 && i_flag_set.timer0 == 8'h00)
    |=> !o_io_regs[`LOC_TIMER0_EVENT_FLAGS][0]
      && o_io_regs[`LOC_TIMER0_EVENT_FLAGS][2:1] == $past(o_io_regs[`LOC_TIMER0_EVENT_FLAGS][2:1]))
    else $error("flag clear touched other flags");

  // Absent port C bit reads as zero
  absent_bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_in && i_req.addr[5:0] == `LOC_PORT_C_INPUT_PINS)
    |=> !o_resp.rdata[3])
    else $error("absent bit not zero");

  // Extended load strobes out, then answers with outside data
  ext_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_data_load && i_req.addr >= `EXT_SPACE_FIRST)
    |=> o_ext.sel && !o_ext.we && o_ext.addr == $past(i_req.addr)
    ##1 o_resp.ack && o_resp.rdata == $past(i_ext_rdata))
    else $error("extended load wrong");

  // Extended store strobes out and gives no answer
  ext_store_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_data_store && i_req.addr >= `EXT_SPACE_FIRST)
    |=> o_ext.sel && o_ext.we && o_ext.wdata == $past(i_req.wdata) && !o_resp.ack)
    else $error("extended store wrong");

  // I/O operations never reach the extended space
  ext_only_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op inside {op_io_in, op_io_out, op_set_io_bit, op_clear_io_bit, op_test_io_bit})
    |=> !o_ext.sel)
    else $error("I/O operation reached extended space");

  // Local accesses answer on the next edge
  one_cycle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.op == op_io_in) |=> o_resp.ack && o_resp.rdata == $past(rd_val))
    else $error("I/O read not answered in one cycle");

  // Reset clears the bank
  reset_clear_a: assert property (@(posedge i_clk)
    i_reset |=> o_io_regs == '0 && !o_resp.ack && !o_ext.sel)
    else $error("reset left state behind");

endmodule

//--- core_model.sv
`timescale 1ns/1ps
module core_model
(
  input wire logic i_clk,
  input io_space_pkg::core_resp_t i_resp,
  input io_space_pkg::ext_req_t i_ext,
  output io_space_pkg::core_req_t o_req,
  output logic [7:0] o_ext_rdata
);
  import io_space_pkg::*;

  // Value handed back on extended loads
  logic [7:0] ext_val = 8'h00;

  initial
  begin
    o_req = '{op_none, 9'h000, 3'h0, 8'h00};
    o_ext_rdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Extended space read data
  // ----------------------------------------------------------------
  // Data only while a load is selected, otherwise a changing pattern
  always @(negedge i_clk)
  begin
    if (i_ext.sel && !i_ext.we)
      o_ext_rdata <= ext_val;
    else
      o_ext_rdata <= ~o_ext_rdata;
  end

  // ----------------------------------------------------------------
  // One core access
  // ----------------------------------------------------------------
  // Request stands one cycle; answer is awaited for three cycles, which
  // also leaves an idle cycle after an extended load
  task automatic access(input core_op_t op, input logic [8:0] a, input logic [2:0] b, input logic [7:0] w,
    output logic [7:0] rd, output logic bv, output logic ak);
    int n;
    ak = 1'b0;
    rd = 8'h00;
    bv = 1'b0;
    @(negedge i_clk);
    o_req = '{op, a, b, w};
    @(negedge i_clk);
    o_req = '{op_none, 9'h000, 3'h0, 8'h00};
    for (n = 0; n < 3; n++)
    begin
      // First answer seen is the one kept
      if (i_resp.ack === 1'b1 && !ak)
      begin
        ak = 1'b1;
        rd = i_resp.rdata;
        bv = i_resp.bit_val;
      end
      @(negedge i_clk);
    end
  endtask
endmodule

//--- io_register_space_tb.sv
`timescale 1ns/1ps
module io_register_space_tb;
  import io_space_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  core_req_t req;
  core_resp_t resp;
  pin_in_t pins = '0;
  flag_set_t flag_set = '0;
  logic [63:0][7:0] io_regs;
  ext_req_t ext;
  ext_req_t last_ext = '0;
  logic [7:0] ext_rdata;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic bv;
  logic ak;
  // Assigned read/write locations and their implemented bits
  logic [5:0] rw_loc [24] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21,
    6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2e, 6'h30, 6'h31};
  logic [7:0] rw_mask [24] = '{8'hff, 8'hff, 8'hf7, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'h0f, 8'h83, 8'hf3, 8'hcf, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // Write-one-to-clear flag locations
  logic [5:0] fl_loc [4] = '{6'h15, 6'h16, 6'h1b, 6'h1c};
  logic [7:0] fl_mask [4] = '{8'h07, 8'h2f, 8'h03, 8'hff};

  always #5 i_clk = ~i_clk;

  io_register_space uut (.i_clk(i_clk), .i_reset(i_reset), .i_req(req), .o_resp(resp), .i_pins(pins),
    .i_flag_set(flag_set), .o_io_regs(io_regs), .o_ext(ext), .i_ext_rdata(ext_rdata));

  core_model core (.i_clk(i_clk), .i_resp(resp), .i_ext(ext), .o_req(req), .o_ext_rdata(ext_rdata));

  // Keep the last extended access seen
  always @(negedge i_clk)
  begin
    if (ext.sel === 1'b1)
      last_ext <= ext;
  end

  // Hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Byte comparison, also used for single bits
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Access through the core model; every access except an extended store is answered
  task automatic go(input core_op_t op, input logic [8:0] a, input logic [2:0] b, input logic [7:0] w);
    core.access(op, a, b, w, rd, bv, ak);
    if (!(op == op_data_store && a >= 9'h060))
      check8("ack", 8'h01, {7'h00, ak});
  endtask

  // Reset for six cycles, released at a falling edge
  task automatic do_reset();
    i_reset = 1'b1;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    int k;
    int i;
    void'($urandom(81));
    do_reset();
    // Random writes on one path, read back on the other
    for (i = 0; i < 40; i++)
    begin
      k = $urandom_range(23);
      d = 8'($urandom()) & rw_mask[k];
      if ($urandom_range(1) == 1)
      begin
        go(op_io_out, {3'h0, rw_loc[k]}, 3'h0, d);
        go(op_data_load, {3'h0, rw_loc[k]} + 9'h020, 3'h0, 8'h00);
      end
      else
      begin
        go(op_data_store, {3'h0, rw_loc[k]} + 9'h020, 3'h0, d);
        go(op_io_in, {3'h0, rw_loc[k]}, 3'h0, 8'h00);
      end
      check8("read back", d, rd & rw_mask[k]);
      check8("stored", d, io_regs[rw_loc[k]] & rw_mask[k]);
    end
    // Bit set, test and clear in the bit range
    go(op_io_out, 9'h005, 3'h0, 8'h00);
    e = 8'h00;
    for (i = 0; i < 8; i++)
    begin
      go(op_set_io_bit, 9'h005, i[2:0], 8'h00);
      e[i] = 1'b1;
      check8("bit set", e, io_regs[5]);
      go(op_test_io_bit, 9'h005, i[2:0], 8'h00);
      check8("bit test", 8'h01, {7'h00, bv});
      go(op_clear_io_bit, 9'h005, 3'(i + 3), 8'h00);
      e[(i + 3) % 8] = 1'b0;
      check8("bit clear", e, io_regs[5]);
      go(op_test_io_bit, 9'h005, 3'(i + 3), 8'h00);
      check8("bit test clear", 8'h00, {7'h00, bv});
    end
    // Bit set above the bit range leaves the register alone
    d = io_regs[6'h2a];
    go(op_set_io_bit, 9'h02a, 3'h7, 8'h00);
    go(op_clear_io_bit, 9'h02a, 3'h0, 8'h00);
    check8("no bit op", d, io_regs[6'h2a]);
    // Data store below the alias base is not an I/O write
    d = io_regs[6'h1e];
    go(op_data_store, 9'h01e, 3'h0, ~d);
    check8("low data", d, io_regs[6'h1e]);
    // Flags: set by hardware, cleared by one, kept by zero
    @(negedge i_clk);
    flag_set = '{8'hff, 8'hff, 8'hff, 8'hff};
    @(negedge i_clk);
    flag_set = '0;
    for (i = 0; i < 4; i++)
    begin
      check8("flags set", fl_mask[i], io_regs[fl_loc[i]]);
      go(op_io_out, {3'h0, fl_loc[i]}, 3'h0, 8'h00);
      check8("zero keeps", fl_mask[i], io_regs[fl_loc[i]]);
      go(op_io_out, {3'h0, fl_loc[i]}, 3'h0, 8'h01);
      check8("one clears", fl_mask[i] & 8'hfe, io_regs[fl_loc[i]]);
      go(op_set_io_bit, {3'h0, fl_loc[i]}, 3'h0, 8'h00);
      check8("rmw clears", 8'h00, io_regs[fl_loc[i]]);
    end
    // Pin levels through the input path, port D through the data alias
    @(negedge i_clk);
    pins = 24'($urandom());
    go(op_io_in, 9'h003, 3'h0, 8'h00);
    check8("pins b", pins.port_b, rd);
    go(op_io_in, 9'h006, 3'h0, 8'h00);
    check8("pins c", pins.port_c & 8'hf7, rd & 8'hf7);
    go(op_data_load, 9'h029, 3'h0, 8'h00);
    check8("pins d", pins.port_d, rd);
    // Extended space through data accesses only
    core.ext_val = 8'($urandom());
    go(op_data_load, 9'h060, 3'h0, 8'h00);
    check8("ext load", core.ext_val, rd);
    check8("ext addr", 8'h60, last_ext.addr[7:0]);
    d = 8'($urandom());
    go(op_data_store, 9'h1ff, 3'h0, d);
    check8("ext we", 8'h01, {7'h00, last_ext.we});
    check8("ext data", d, last_ext.wdata);
    check8("ext top", 8'hff, last_ext.addr[7:0]);
    check8("ext top msb", 8'h01, {7'h00, last_ext.addr[8]});
    // Second reset restores every register
    do_reset();
    for (i = 0; i < 24; i++)
      check8("reset value", 8'h00, io_regs[rw_loc[i]]);
    close_out();
  end
endmodule
